// file: include/pmra_defs.svh
`ifndef PMRA_DEFS_SVH
`define PMRA_DEFS_SVH

// FIFO byte count width
`define PMRA_CW          12

// Register byte offsets
`define PMRA_OFS_DMA     8'h00
`define PMRA_OFS_TXBURST 8'h04
`define PMRA_OFS_TXPRIO  8'h08
`define PMRA_OFS_RXBURST 8'h0c
`define PMRA_OFS_RXPRIO  8'h10
`define PMRA_OFS_STATUS  8'h14

// Control field positions
`define PMRA_BIT_INV_DEF 0
`define PMRA_BIT_RDL_DEF 1

// Reset values
`define PMRA_RST_DMA     2'h0
`define PMRA_RST_THR     12'h000

// Least free space for a standard transmit request
`define PMRA_TX_MIN_FREE 12'h010

// PCI memory command codes
`define PMRA_CMD_MR      4'h6
`define PMRA_CMD_MW      4'h7
`define PMRA_CMD_MRM     4'hc
`define PMRA_CMD_MRL     4'he
`define PMRA_CMD_MWI     4'hf

`endif

// file: include/pmra_pkg.sv
`include "pmra_defs.svh"

package pmra_pkg;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_TX   = 2'b01,
    S_RX   = 2'b10
  } pmra_state_t;

  // Transmit engine view
  typedef struct packed {
    logic                 frag_avail;
    logic                 desc_fetch;
    logic [`PMRA_CW-1:0] free;
    logic [`PMRA_CW-1:0] used;
    logic [`PMRA_CW-1:0] left;
  } pmra_tx_t;

  // Receive engine view
  typedef struct packed {
    logic                 visible;
    logic                 buf_avail;
    logic                 desc_write;
    logic [`PMRA_CW-1:0] used;
    logic [`PMRA_CW-1:0] free;
    logic [`PMRA_CW-1:0] left;
  } pmra_rx_t;

  typedef struct packed {
    pmra_state_t          st;
    logic                 last_rx;
    logic [3:0]           cmd;
    logic                 inv_defeat;
    logic                 rdl_defeat;
    logic [`PMRA_CW-1:0] tx_burst_thr;
    logic [`PMRA_CW-1:0] tx_prio_thr;
    logic [`PMRA_CW-1:0] rx_burst_thr;
    logic [`PMRA_CW-1:0] rx_prio_thr;
    logic [31:0]          rdata;
  } pmra_state_s_t;

endpackage

// file: rtl/pmra_arbiter.sv
// Summary of operation
// - A fresh PCI memory command is chosen at every burst grant.
// - Descriptor fetches always use plain Memory Read.
// - Transmit data reads pick MR, MRL or MRM from bytes, space, rx.
// - Descriptor status writes always use plain Memory Write.
// - Receive data writes pick MW or MWI from bytes, data, tx.
// - MWI only while the system invalidate enable bit is set.
// - Invalidate defeat bit blocks MWI; reset leaves MWI allowed.
// - Read line defeat bit blocks MRL; reset leaves MRL allowed.
// - Transmit standard request needs 16 free bytes and a fragment.
// - Transmit standard request passes only if free exceeds threshold.
// - Transmit priority request when used bytes below threshold.
// - Transmit priority request bypasses the burst threshold.
// - Receive standard request needs visible packet and host buffer.
// - Receive standard request passes only if count exceeds threshold.
// - Receive priority request when free space below threshold.
// - Fixed order: rx priority, tx priority, then standard ones.
// - Both standard requests alone: grants alternate rx and tx.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "pmra_defs.svh"

module pmra_arbiter #(
  parameter logic [`PMRA_CW-1:0] LINE_BYTES = 12'h020
) (
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RSTN,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output      logic [31:0]          PRDATA,
  output      logic                 PREADY,
  output      logic                 PSLVERR,
  // Engines
  input  wire pmra_pkg::pmra_tx_t   TX_ENG,
  input  wire pmra_pkg::pmra_rx_t   RX_ENG,
  // PCI configuration and master interface
  input  wire logic                 PCI_INVALIDATE_ENABLE,
  input  wire logic                 BURST_DONE,
  output      logic                 BUS_REQ,
  output      logic                 GRANT_TX,
  output      logic                 GRANT_RX,
  output      logic [3:0]           PCI_CMD
);

  localparam logic [`PMRA_CW:0] LINE2 = {LINE_BYTES, 1'b0};
  // Reset image of the two defeat bits
  localparam logic [1:0] RST_DMA = `PMRA_RST_DMA;

  pmra_pkg::pmra_state_s_t q;
  pmra_pkg::pmra_state_s_t d;

  logic tx_standard_req;
  logic tx_priority_req;
  logic rx_standard_req;
  logic rx_priority_req;
  logic tx_std_q;
  logic rx_std_q;
  logic tx_any;
  logic rx_any;
  logic mwi_ok;
  logic idle;
  logic mapped;
  logic setup;
  logic wr_acc;
  logic [31:0] rd_mux;
  logic [3:0] tx_cmd;
  logic [3:0] rx_cmd;

  // Engine requests
  assign tx_standard_req = TX_ENG.frag_avail &&
                           (TX_ENG.free >= `PMRA_TX_MIN_FREE);
  assign tx_std_q = tx_standard_req &&
                    (TX_ENG.free > q.tx_burst_thr);
  assign tx_priority_req = TX_ENG.used < q.tx_prio_thr;
  assign rx_standard_req = RX_ENG.visible && RX_ENG.buf_avail;
  assign rx_std_q = rx_standard_req &&
                    (RX_ENG.used > q.rx_burst_thr);
  assign rx_priority_req = RX_ENG.free < q.rx_prio_thr;
  assign tx_any = tx_std_q || tx_priority_req;
  assign rx_any = rx_std_q || rx_priority_req;

  assign mwi_ok = PCI_INVALIDATE_ENABLE && !q.inv_defeat;
  assign idle = (q.st == pmra_pkg::S_IDLE);

  // Transmit read command
  // Long MRM bursts yield to a waiting receive engine to avert overrun
  always_comb
  begin
    tx_cmd = `PMRA_CMD_MR;
    if (TX_ENG.desc_fetch)
    begin
      tx_cmd = `PMRA_CMD_MR;
    end
    else if (({1'b0, TX_ENG.left} >= LINE2) &&
             ({1'b0, TX_ENG.free} >= LINE2) && !rx_any)
    begin
      tx_cmd = `PMRA_CMD_MRM;
    end
    else if ((TX_ENG.left >= LINE_BYTES) &&
             (TX_ENG.free >= LINE_BYTES) && !q.rdl_defeat)
    begin
      tx_cmd = `PMRA_CMD_MRL;
    end
  end

  // Receive write command
  // MWI waits while transmit requests, so its FIFO does not run dry
  always_comb
  begin
    rx_cmd = `PMRA_CMD_MW;
    if (RX_ENG.desc_write)
    begin
      rx_cmd = `PMRA_CMD_MW;
    end
    else if (mwi_ok && (RX_ENG.left >= LINE_BYTES) &&
             (RX_ENG.used >= LINE_BYTES) && !tx_any)
    begin
      rx_cmd = `PMRA_CMD_MWI;
    end
  end

  // APB decode
  // Read data is captured at setup so PRDATA comes from a flop
  // Unmapped offsets answer with an error and change nothing
  assign setup = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE && mapped;
  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (PADDR)
      `PMRA_OFS_DMA:
      begin
        rd_mux[`PMRA_BIT_INV_DEF] = q.inv_defeat;
        rd_mux[`PMRA_BIT_RDL_DEF] = q.rdl_defeat;
      end
      `PMRA_OFS_TXBURST: rd_mux[`PMRA_CW-1:0] = q.tx_burst_thr;
      `PMRA_OFS_TXPRIO:  rd_mux[`PMRA_CW-1:0] = q.tx_prio_thr;
      `PMRA_OFS_RXBURST: rd_mux[`PMRA_CW-1:0] = q.rx_burst_thr;
      `PMRA_OFS_RXPRIO:  rd_mux[`PMRA_CW-1:0] = q.rx_prio_thr;
      `PMRA_OFS_STATUS:
        rd_mux[11:0] = {q.cmd, q.last_rx, q.st, mwi_ok,
                        rx_priority_req, tx_priority_req,
                        rx_std_q, tx_std_q};
      default:           mapped = 1'b0;
    endcase
  end

  // Next state
  // Grants are decided only while idle; a running burst is never cut
  always_comb
  begin
    d = q;
    if (setup)
    begin
      d.rdata = rd_mux;
    end
    if (wr_acc)
    begin
      unique case (PADDR)
        `PMRA_OFS_DMA:
        begin
          d.inv_defeat = PWDATA[`PMRA_BIT_INV_DEF];
          d.rdl_defeat = PWDATA[`PMRA_BIT_RDL_DEF];
        end
        `PMRA_OFS_TXBURST: d.tx_burst_thr = PWDATA[`PMRA_CW-1:0];
        `PMRA_OFS_TXPRIO:  d.tx_prio_thr = PWDATA[`PMRA_CW-1:0];
        `PMRA_OFS_RXBURST: d.rx_burst_thr = PWDATA[`PMRA_CW-1:0];
        `PMRA_OFS_RXPRIO:  d.rx_prio_thr = PWDATA[`PMRA_CW-1:0];
        default:           d.rdata = q.rdata;
      endcase
    end
    unique case (q.st)
      pmra_pkg::S_IDLE:
      begin
        // Fixed priority; standard pair alternates on last winner
        if (rx_priority_req ||
            (!tx_priority_req && rx_std_q && !(tx_std_q && q.last_rx)))
        begin
          d.st = pmra_pkg::S_RX;
          d.last_rx = 1'b1;
          d.cmd = rx_cmd;
        end
        else if (tx_priority_req || tx_std_q)
        begin
          d.st = pmra_pkg::S_TX;
          d.last_rx = 1'b0;
          d.cmd = tx_cmd;
        end
      end
      pmra_pkg::S_TX, pmra_pkg::S_RX:
      begin
        if (BURST_DONE)
        begin
          d.st = pmra_pkg::S_IDLE;
        end
      end
      default: d.st = pmra_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      q.st           <= pmra_pkg::S_IDLE;
      q.last_rx      <= 1'b0;
      q.cmd          <= `PMRA_CMD_MR;
      q.inv_defeat   <= RST_DMA[`PMRA_BIT_INV_DEF];
      q.rdl_defeat   <= RST_DMA[`PMRA_BIT_RDL_DEF];
      q.tx_burst_thr <= `PMRA_RST_THR;
      q.tx_prio_thr  <= `PMRA_RST_THR;
      q.rx_burst_thr <= `PMRA_RST_THR;
      q.rx_prio_thr  <= `PMRA_RST_THR;
      q.rdata        <= 32'h0000_0000;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs
  assign PRDATA   = q.rdata;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL && PENABLE && !mapped;
  assign BUS_REQ  = idle && (tx_any || rx_any);
  assign GRANT_TX = (q.st == pmra_pkg::S_TX);
  assign GRANT_RX = (q.st == pmra_pkg::S_RX);
  assign PCI_CMD  = q.cmd;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  sequence seq_idle_rx_prio;
    idle && rx_priority_req;
  endsequence

  sequence seq_idle_tx_only_prio;
    idle && !rx_priority_req && tx_priority_req;
  endsequence

  sequence seq_idle_std_pair;
    idle && !rx_priority_req && !tx_priority_req && rx_std_q && tx_std_q;
  endsequence

  chk_desc_read_mr: assert property (
    idle && !rx_any && tx_any && TX_ENG.desc_fetch |=>
      GRANT_TX && PCI_CMD == `PMRA_CMD_MR)
    else $error("descriptor fetch not issued as memory read");

  chk_desc_write_mw: assert property (
    $rose(GRANT_RX) && $past(RX_ENG.desc_write) |->
      PCI_CMD == `PMRA_CMD_MW)
    else $error("descriptor write not issued as memory write");

  chk_tx_read_cmd: assert property (
    $rose(GRANT_TX) |-> PCI_CMD inside
      {`PMRA_CMD_MR, `PMRA_CMD_MRL, `PMRA_CMD_MRM})
    else $error("transmit burst with illegal command");

  chk_mwi_gate: assert property (
    $rose(GRANT_RX) && PCI_CMD == `PMRA_CMD_MWI |->
      $past(PCI_INVALIDATE_ENABLE) && !$past(q.inv_defeat) &&
      !$past(tx_any))
    else $error("invalidate write issued while not allowed");

  chk_mrl_defeat: assert property (
    $rose(GRANT_TX) && PCI_CMD == `PMRA_CMD_MRL |-> !$past(q.rdl_defeat))
    else $error("read line issued while defeated");

  chk_rx_prio_first: assert property (
    seq_idle_rx_prio |=> GRANT_RX)
    else $error("receive priority request not served first");

  chk_tx_prio_next: assert property (
    seq_idle_tx_only_prio |=> GRANT_TX)
    else $error("transmit priority request not served second");

  chk_std_alternate: assert property (
    seq_idle_std_pair |=> (GRANT_TX == $past(q.last_rx)) && !idle)
    else $error("standard requests did not alternate");

  chk_tx_std_qual: assert property (
    $rose(GRANT_TX) && !$past(tx_priority_req) |->
      $past(TX_ENG.frag_avail) &&
      $past(TX_ENG.free) >= `PMRA_TX_MIN_FREE &&
      $past(TX_ENG.free) > $past(q.tx_burst_thr))
    else $error("transmit standard grant without qualification");

  chk_rx_std_qual: assert property (
    $rose(GRANT_RX) && !$past(rx_priority_req) |->
      $past(RX_ENG.visible) && $past(RX_ENG.buf_avail) &&
      $past(RX_ENG.used) > $past(q.rx_burst_thr))
    else $error("receive standard grant without qualification");

  chk_one_grant: assert property (
    !(GRANT_TX && GRANT_RX) && !((GRANT_TX || GRANT_RX) && BUS_REQ))
    else $error("more than one grant or request during grant");

  chk_grant_hold: assert property (
    (GRANT_TX || GRANT_RX) && !BURST_DONE |=>
      $stable(GRANT_TX) && $stable(GRANT_RX) && $stable(PCI_CMD))
    else $error("grant or command changed inside a burst");

  chk_grant_release: assert property (
    (GRANT_TX || GRANT_RX) && BURST_DONE |=> idle)
    else $error("grant not released after burst end");

  sequence seq_idle_any_req;
    idle && (tx_any || rx_any);
  endsequence

  chk_idle_served: assert property (
    seq_idle_any_req |=> !idle && (GRANT_TX || GRANT_RX))
    else $error("pending request left waiting while idle");

  chk_mrm_no_rx: assert property (
    $rose(GRANT_TX) && PCI_CMD == `PMRA_CMD_MRM |->
      !$past(rx_any) && !$past(TX_ENG.desc_fetch))
    else $error("read multiple issued while receive requests");

  chk_rx_write_cmd: assert property (
    $rose(GRANT_RX) |-> PCI_CMD inside {`PMRA_CMD_MW, `PMRA_CMD_MWI})
    else $error("receive burst with illegal command");

  chk_reset_allow: assert property (
    !$past(RSTN) |-> !q.inv_defeat && !q.rdl_defeat)
    else $error("defeat bits not clear after reset");

  chk_unmapped_safe: assert property (
    PSEL && PENABLE && PWRITE && !mapped |=>
      $stable(q.inv_defeat) && $stable(q.rdl_defeat) &&
      $stable(q.tx_burst_thr) && $stable(q.rx_burst_thr))
    else $error("write to unmapped offset changed a register");

endmodule // pmra_arbiter

// file: tb/pmra_pci_model.sv
`timescale 1ns/1ns

module pmra_pci_model (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RSTN,
  // Grants and burst length
  input  wire logic       GRANT_TX,
  input  wire logic       GRANT_RX,
  input  wire logic [3:0] LEN,
  // Burst end
  output      logic       BURST_DONE
);
  logic [3:0] cnt_q;

  // Ends a granted burst after LEN extra cycles, one pulse per burst
  always @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      cnt_q <= 4'h0;
      BURST_DONE <= 1'b0;
    end
    else if ((GRANT_TX | GRANT_RX) && !BURST_DONE && cnt_q == LEN)
    begin
      cnt_q <= 4'h0;
      BURST_DONE <= 1'b1;
    end
    else
    begin
      cnt_q <= (GRANT_TX | GRANT_RX) && !BURST_DONE ? cnt_q + 4'h1 : 4'h0;
      BURST_DONE <= 1'b0;
    end
endmodule // pmra_pci_model

// file: tb/pci_master_request_arbiter_tb.sv
`timescale 1ns/1ns
`include "pmra_defs.svh"

module pci_master_request_arbiter_tb;
  localparam pmra_pkg::pmra_tx_t TX0 = {2'h0, 12'h000, 12'h800, 12'h000};
  localparam pmra_pkg::pmra_rx_t RX0 = {3'h0, 12'h000, 12'h800, 12'h000};
  logic               clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic               inv_en, done, bus_req, g_tx, g_rx, pg_tx, pg_rx, pdone;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         cmd, len;
  pmra_pkg::pmra_tx_t tx;
  pmra_pkg::pmra_rx_t rx;
  logic [32:0]        q_apb[$];
  logic [5:0]         q_gnt[$];
  int                 n_mismatch, samples_checked, cycles, seed;

  pmra_arbiter i_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_ENG(tx),
    .RX_ENG(rx), .PCI_INVALIDATE_ENABLE(inv_en), .BURST_DONE(done),
    .BUS_REQ(bus_req), .GRANT_TX(g_tx), .GRANT_RX(g_rx), .PCI_CMD(cmd));
  pmra_pci_model i_pci (.CLK(clk), .RSTN(rstn), .GRANT_TX(g_tx),
    .GRANT_RX(g_rx), .LEN(len), .BURST_DONE(done));

  function automatic pmra_pkg::pmra_tx_t mtx(logic f, logic d,
      logic [11:0] fr, logic [11:0] u, logic [11:0] l);
    return {f, d, fr, u, l};
  endfunction

  function automatic pmra_pkg::pmra_rx_t mrx(logic v, logic b, logic d,
      logic [11:0] u, logic [11:0] fr, logic [11:0] l);
    return {v, b, d, u, fr, l};
  endfunction

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    chk(33'(q_gnt.size()), 33'h0);
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [32:0] e);
    if (!w)
      q_apb.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic noreq(input pmra_pkg::pmra_tx_t t,
      input pmra_pkg::pmra_rx_t r);
    tx <= t;
    rx <= r;
    @(negedge clk);
    chk(33'(bus_req), 33'h0);
    @(posedge clk);
    tx <= TX0;
    rx <= RX0;
    @(posedge clk);
  endtask

  task automatic burst(input pmra_pkg::pmra_tx_t t,
      input pmra_pkg::pmra_rx_t r, input logic [5:0] e);
    int k;
    q_gnt.push_back(e);
    tx <= t;
    rx <= r;
    len <= 4'($random(seed));
    @(negedge clk);
    chk(33'(bus_req), 33'h1);
    @(posedge clk);
    // Requests stand until every grant noted for them has been seen
    for (k = 0; k < 80 && q_gnt.size() > 0; k++)
      @(posedge clk);
    if (k == 80)
      n_mismatch++;
    tx <= TX0;
    rx <= RX0;
    for (k = 0; k < 40 && (g_tx | g_rx); k++)
      @(posedge clk);
    if (k == 40)
      n_mismatch++;
    @(posedge clk);
  endtask

  always @(posedge clk)
    if (psel && penable && pready && !pwrite && q_apb.size() > 0)
      chk({pslverr, prdata}, q_apb.pop_front());

  always @(negedge clk)
  begin
    if ((g_tx | g_rx) && !(pg_tx | pg_rx) && q_gnt.size() > 0)
      chk(33'({g_rx, g_tx, cmd}), 33'(q_gnt.pop_front()));
    if (pg_tx | pg_rx)
      chk(33'({g_rx, g_tx}), pdone ? 33'h0 : 33'({pg_rx, pg_tx}));
    pg_tx = g_tx;
    pg_rx = g_rx;
    pdone = done;
  end

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    seed = 20;
    {rstn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata} = 40'h0;
    tx = TX0;
    rx = RX0;
    inv_en = 1'b1;
    len = 4'h2;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, `PMRA_OFS_DMA, 32'h0, 33'h0);
    apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h18, 32'h0000_0003, 33'h0);
    apb(1'b0, `PMRA_OFS_DMA, 32'h0, 33'h0);
    noreq(mtx(1'b1, 1'b0, 12'h00f, 12'h100, 12'h040), RX0);
    noreq(mtx(1'b0, 1'b0, 12'h100, 12'h100, 12'h040), RX0);
    noreq(TX0, mrx(1'b0, 1'b1, 1'b0, 12'h100, 12'h100, 12'h040));
    burst(mtx(1'b1, 1'b0, 12'h010, 12'h100, 12'h040), RX0,
      {2'h1, `PMRA_CMD_MR});
    $display("reset and floor tests done");
    apb(1'b1, `PMRA_OFS_TXBURST, 32'h40, 33'h0);
    apb(1'b1, `PMRA_OFS_RXBURST, 32'h40, 33'h0);
    apb(1'b1, `PMRA_OFS_TXPRIO, 32'h10, 33'h0);
    apb(1'b1, `PMRA_OFS_RXPRIO, 32'h10, 33'h0);
    apb(1'b0, `PMRA_OFS_TXBURST, 32'h0, 33'h40);
    noreq(mtx(1'b1, 1'b0, 12'h040, 12'h020, 12'h040), RX0);
    noreq(TX0, mrx(1'b1, 1'b1, 1'b0, 12'h040, 12'h100, 12'h040));
    burst(mtx(1'b1, 1'b0, 12'h041, 12'h020, 12'h040), RX0,
      {2'h1, `PMRA_CMD_MRM});
    burst(mtx(1'b1, 1'b1, 12'h041, 12'h020, 12'h040), RX0,
      {2'h1, `PMRA_CMD_MR});
    burst(TX0, mrx(1'b1, 1'b1, 1'b0, 12'h041, 12'h100, 12'h020),
      {2'h2, `PMRA_CMD_MWI});
    burst(TX0, mrx(1'b1, 1'b1, 1'b1, 12'h041, 12'h100, 12'h020),
      {2'h2, `PMRA_CMD_MW});
    inv_en <= 1'b0;
    burst(TX0, mrx(1'b1, 1'b1, 1'b0, 12'h041, 12'h100, 12'h020),
      {2'h2, `PMRA_CMD_MW});
    inv_en <= 1'b1;
    apb(1'b1, `PMRA_OFS_DMA, 32'h1, 33'h0);
    apb(1'b0, `PMRA_OFS_DMA, 32'h0, 33'h1);
    burst(TX0, mrx(1'b1, 1'b1, 1'b0, 12'h041, 12'h100, 12'h020),
      {2'h2, `PMRA_CMD_MW});
    burst(mtx(1'b1, 1'b0, 12'h041, 12'h020, 12'h020), RX0,
      {2'h1, `PMRA_CMD_MRL});
    apb(1'b1, `PMRA_OFS_DMA, 32'h2, 33'h0);
    burst(mtx(1'b1, 1'b0, 12'h041, 12'h020, 12'h020), RX0,
      {2'h1, `PMRA_CMD_MR});
    apb(1'b1, `PMRA_OFS_DMA, 32'h0, 33'h0);
    apb(1'b0, `PMRA_OFS_STATUS, 32'h0, 33'h610);
    $display("command tests done");
    burst(mtx(1'b0, 1'b0, 12'h010, 12'h00f, 12'(5'($random(seed)))), RX0,
      {2'h1, `PMRA_CMD_MR});
    burst(TX0, mrx(1'b0, 1'b0, 1'b0, 12'h000, 12'h00f, 12'h010),
      {2'h2, `PMRA_CMD_MW});
    burst(mtx(1'b0, 1'b0, 12'h010, 12'h00f, 12'h010),
      mrx(1'b0, 1'b0, 1'b0, 12'h000, 12'h00f, 12'h010),
      {2'h2, `PMRA_CMD_MW});
    burst(mtx(1'b0, 1'b0, 12'h010, 12'h00f, 12'h010),
      mrx(1'b1, 1'b1, 1'b0, 12'h041, 12'h100, 12'h040),
      {2'h1, `PMRA_CMD_MR});
    repeat (2)
    begin
      q_gnt.push_back({2'h2, `PMRA_CMD_MW});
      burst(mtx(1'b1, 1'b0, 12'h041, 12'h020, 12'h040),
        mrx(1'b1, 1'b1, 1'b0, 12'h041, 12'h100, 12'h040),
        {2'h1, `PMRA_CMD_MRL});
    end
    $display("arbitration tests done");
    close_out();
  end
endmodule // pci_master_request_arbiter_tb
